// *** rtl/eifp_pkg.sv ***
// Constants, field layouts and carrier types of the external request
// flag and priority block.
// Assumes one 25 MHz clock and an AXI4-Lite register bus of 32 bits.
package eifp_pkg;

	// ==================================================================
	// Sizes
	localparam int FLAG_N = 3;
	localparam int SRC_N  = 10;
	localparam int SRC_W  = 4;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;

	// ==================================================================
	// Register indices; byte address is four times the index
	localparam logic [9:0] IDX_SENSE    = 10'h0F4;
	localparam logic [9:0] IDX_ENABLE   = 10'h0F5;
	localparam logic [9:0] IDX_FLAGS    = 10'h0F6;
	localparam logic [9:0] IDX_PRIO_A   = 10'h0F8;
	localparam logic [9:0] IDX_PRIO_B   = 10'h0F9;
	localparam logic [9:0] IDX_EVT_STAT = 10'h0FA;
	localparam logic [9:0] IDX_EVT_MASK = 10'h0FB;

	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==================================================================
	// Flag bit positions for pins 0, 1 and 4
	localparam int POS_PIN0 = 0;
	localparam int POS_PIN1 = 1;
	localparam int POS_PIN4 = 4;

	// Source numbering: default order, lowest number served first
	localparam logic [SRC_W-1:0] SRC_PIN0   = 4'h0;
	localparam logic [SRC_W-1:0] SRC_PIN1   = 4'h1;
	localparam logic [SRC_W-1:0] SRC_PIN4   = 4'h2;
	localparam int               SRC_TIMER0 = 3;
	localparam int               SRC_SERIAL = 8;
	localparam int               SRC_CONV   = 9;

	// ==================================================================
	// Carriers
	typedef struct packed {
		logic             valid;
		logic [SRC_W-1:0] src;
	} eifp_ack_s;

	typedef struct packed {
		logic             pending;
		logic [SRC_W-1:0] src;
	} eifp_req_s;

	typedef struct packed {
		logic              go;
		logic [ADDR_W-1:0] addr;
		logic [7:0]        data;
		logic              strb;
	} eifp_wr_s;

	typedef struct packed {
		logic              go;
		logic [ADDR_W-1:0] addr;
	} eifp_rd_s;

	// ==================================================================
	// Functions
	function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
		input logic [9:0] idx);
		reg_hit = (addr[1:0] == 2'h0) && (addr[ADDR_W-1:2] == idx);
	endfunction

	function automatic logic [7:0] pack_flags(input logic [2:0] f);
		pack_flags = 8'h00;
		pack_flags[POS_PIN0] = f[0];
		pack_flags[POS_PIN1] = f[1];
		pack_flags[POS_PIN4] = f[2];
	endfunction

	function automatic logic [2:0] unpack_flags(input logic [7:0] b);
		unpack_flags = {b[POS_PIN4], b[POS_PIN1], b[POS_PIN0]};
	endfunction

	// Priority level of every source from the two priority registers
	function automatic logic [SRC_N-1:0] src_level(input logic [7:0] a,
		input logic [7:0] b);
		src_level = {b[1], b[3], b[6], b[7], a[0], a[1], a[2],
			a[4], a[6], a[7]};
	endfunction

endpackage

// *** rtl/eifp_axi_slave.sv ***
// AXI4-Lite slave front end: turns bus transfers into one-cycle
// register write and read strobes.
// Assumes the register file answers read data and decode errors
// combinationally in the strobe cycle.
`timescale 1ns/10ps
`default_nettype none
module eifp_axi_slave (
	// Clock and reset
	input  wire logic                            clk,
	input  wire logic                            reset,
	// Write address and data
	input  wire logic                            awvalid,
	output logic                                 awready,
	input  wire logic [eifp_pkg::ADDR_W-1:0]     awaddr,
	input  wire logic                            wvalid,
	output logic                                 wready,
	input  wire logic [eifp_pkg::DATA_W-1:0]     wdata,
	input  wire logic [3:0]                      wstrb,
	// Write response
	output logic                                 bvalid,
	input  wire logic                            bready,
	output logic [1:0]                           bresp,
	// Read channels
	input  wire logic                            arvalid,
	output logic                                 arready,
	input  wire logic [eifp_pkg::ADDR_W-1:0]     araddr,
	output logic                                 rvalid,
	input  wire logic                            rready,
	output logic [eifp_pkg::DATA_W-1:0]          rdata,
	output logic [1:0]                           rresp,
	// Register file side
	output eifp_pkg::eifp_wr_s                   wr,
	output eifp_pkg::eifp_rd_s                   rd,
	input  wire logic [7:0]                      rd_data,
	input  wire logic                            rd_err,
	input  wire logic                            wr_err
);
	logic                        aw_have_ff, nxt_aw_have;
	logic                        w_have_ff, nxt_w_have;
	logic [eifp_pkg::ADDR_W-1:0] aw_addr_ff, nxt_aw_addr;
	logic [7:0]                  w_data_ff, nxt_w_data;
	logic                        w_strb_ff, nxt_w_strb;
	logic                        bvalid_ff, nxt_bvalid;
	logic [1:0]                  bresp_ff, nxt_bresp;
	logic                        rvalid_ff, nxt_rvalid;
	logic [7:0]                  rdata_ff, nxt_rdata;
	logic [1:0]                  rresp_ff, nxt_rresp;
	logic                        wr_go;

	// ==================================================================
	// Handshakes
	assign awready = !aw_have_ff;
	assign wready  = !w_have_ff;
	assign arready = !rvalid_ff;
	assign wr_go   = aw_have_ff && w_have_ff && !bvalid_ff;

	assign wr = '{go: wr_go, addr: aw_addr_ff, data: w_data_ff,
		strb: w_strb_ff};
	assign rd = '{go: arvalid && arready, addr: araddr};

	assign bvalid = bvalid_ff;
	assign bresp  = bresp_ff;
	assign rvalid = rvalid_ff;
	assign rresp  = rresp_ff;
	assign rdata  = {24'h000000, rdata_ff};

	always_comb begin
		nxt_aw_have = aw_have_ff;
		nxt_aw_addr = aw_addr_ff;
		nxt_w_have  = w_have_ff;
		nxt_w_data  = w_data_ff;
		nxt_w_strb  = w_strb_ff;
		nxt_bvalid  = bvalid_ff;
		nxt_bresp   = bresp_ff;
		nxt_rvalid  = rvalid_ff;
		nxt_rdata   = rdata_ff;
		nxt_rresp   = rresp_ff;
		if (awvalid && awready) begin
			nxt_aw_have = 1'b1;
			nxt_aw_addr = awaddr;
		end
		if (wvalid && wready) begin
			nxt_w_have = 1'b1;
			nxt_w_data = wdata[7:0];
			nxt_w_strb = wstrb[0];
		end
		if (bvalid_ff && bready)
			nxt_bvalid = 1'b0;
		if (wr_go) begin
			nxt_aw_have = 1'b0;
			nxt_w_have  = 1'b0;
			nxt_bvalid  = 1'b1;
			nxt_bresp   = wr_err ? eifp_pkg::RESP_SLVERR
				: eifp_pkg::RESP_OKAY;
		end
		if (rvalid_ff && rready)
			nxt_rvalid = 1'b0;
		if (rd.go) begin
			nxt_rvalid = 1'b1;
			nxt_rdata  = rd_err ? eifp_pkg::REG_RESET : rd_data;
			nxt_rresp  = rd_err ? eifp_pkg::RESP_SLVERR
				: eifp_pkg::RESP_OKAY;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			aw_have_ff <= 1'b0;
			aw_addr_ff <= '0;
			w_have_ff  <= 1'b0;
			w_data_ff  <= eifp_pkg::REG_RESET;
			w_strb_ff  <= 1'b0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= eifp_pkg::RESP_OKAY;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= eifp_pkg::REG_RESET;
			rresp_ff   <= eifp_pkg::RESP_OKAY;
		end else begin
			aw_have_ff <= nxt_aw_have;
			aw_addr_ff <= nxt_aw_addr;
			w_have_ff  <= nxt_w_have;
			w_data_ff  <= nxt_w_data;
			w_strb_ff  <= nxt_w_strb;
			bvalid_ff  <= nxt_bvalid;
			bresp_ff   <= nxt_bresp;
			rvalid_ff  <= nxt_rvalid;
			rdata_ff   <= nxt_rdata;
			rresp_ff   <= nxt_rresp;
		end
	end
endmodule
`default_nettype wire

// *** rtl/eifp_arbiter.sv ***
// Fixed two-level priority selection among all interrupt sources.
// Assumes request and level vectors in the package source numbering.
`timescale 1ns/10ps
`default_nettype none
module eifp_arbiter (
	// Sources
	input  wire logic [eifp_pkg::SRC_N-1:0] req,
	input  wire logic [eifp_pkg::SRC_N-1:0] level,
	// Selection
	output eifp_pkg::eifp_req_s             pick
);
	logic want_high;

	// ==================================================================
	// High level first, lowest source number within a level
	always_comb begin
		want_high = |(req & level);
		pick      = '0;
		for (int i = eifp_pkg::SRC_N - 1; i >= 0; i--) begin
			if (req[i] && (level[i] == want_high)) begin
				pick.pending = 1'b1;
				pick.src     = eifp_pkg::SRC_W'(i);
			end
		end
	end
endmodule
`default_nettype wire

// *** rtl/eifp_top.sv ***
// External request flags, enable and sense registers, two priority
// registers and the selection of the request offered to the CPU.
// Assumes pins sampled on clk and a CPU that acknowledges the source
// whose exception handling it carries out with a one-cycle pulse.
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/10ps
`default_nettype none
module eifp_top (
	// Clock and reset
	input  wire logic                        clk,
	input  wire logic                        reset,
	// AXI4-Lite write
	input  wire logic                        awvalid,
	output logic                             awready,
	input  wire logic [eifp_pkg::ADDR_W-1:0] awaddr,
	input  wire logic                        wvalid,
	output logic                             wready,
	input  wire logic [eifp_pkg::DATA_W-1:0] wdata,
	input  wire logic [3:0]                  wstrb,
	output logic                             bvalid,
	input  wire logic                        bready,
	output logic [1:0]                       bresp,
	// AXI4-Lite read
	input  wire logic                        arvalid,
	output logic                             arready,
	input  wire logic [eifp_pkg::ADDR_W-1:0] araddr,
	output logic                             rvalid,
	input  wire logic                        rready,
	output logic [eifp_pkg::DATA_W-1:0]      rdata,
	output logic [1:0]                       rresp,
	// External pins 4, 1, 0 as bits 2, 1, 0
	input  wire logic [2:0]                  external_request_pin_n,
	// Other interrupt sources
	input  wire logic [4:0]                  timer_unit_req,
	input  wire logic                        serial_unit_req,
	input  wire logic                        converter_req,
	// CPU exception side
	input  wire eifp_pkg::eifp_ack_s         cpu_ack,
	output eifp_pkg::eifp_req_s              cpu_req,
	// Event interrupt
	output logic                             irq
);
	eifp_pkg::eifp_wr_s          wr;
	eifp_pkg::eifp_rd_s          rd;
	eifp_pkg::eifp_req_s         pick;
	eifp_pkg::eifp_req_s         cpu_req_ff;
	logic [7:0]                  rd_data;
	logic                        rd_err;
	logic                        wr_err;
	logic [2:0]                  flag_ff, nxt_flag;
	logic [2:0]                  armed_ff, nxt_armed;
	logic [2:0]                  pin_prev_ff;
	logic [2:0]                  sense_ff, nxt_sense;
	logic [2:0]                  enable_ff, nxt_enable;
	logic [7:0]                  prio_a_ff, nxt_prio_a;
	logic [7:0]                  prio_b_ff, nxt_prio_b;
	logic [2:0]                  stat_ff, nxt_stat;
	logic [2:0]                  mask_ff, nxt_mask;
	logic                        irq_ff, nxt_irq;
	logic [2:0]                  set_lvl, set_edge, set_any;
	logic [2:0]                  ack_hit, auto_clr, sw_clr;
	logic                        wr_flags, rd_flags, rd_stat;
	logic [2:0]                  wr_bits;
	logic [eifp_pkg::SRC_N-1:0]  src_req;
	logic [eifp_pkg::SRC_N-1:0]  src_lvl;

	// ==================================================================
	// Bus front end and selection
	eifp_axi_slave u_axi (
		.clk     (clk),
		.reset   (reset),
		.awvalid (awvalid),
		.awready (awready),
		.awaddr  (awaddr),
		.wvalid  (wvalid),
		.wready  (wready),
		.wdata   (wdata),
		.wstrb   (wstrb),
		.bvalid  (bvalid),
		.bready  (bready),
		.bresp   (bresp),
		.arvalid (arvalid),
		.arready (arready),
		.araddr  (araddr),
		.rvalid  (rvalid),
		.rready  (rready),
		.rdata   (rdata),
		.rresp   (rresp),
		.wr      (wr),
		.rd      (rd),
		.rd_data (rd_data),
		.rd_err  (rd_err),
		.wr_err  (wr_err)
	);

	assign src_req = {converter_req, serial_unit_req, timer_unit_req,
		flag_ff & enable_ff};
	assign src_lvl = eifp_pkg::src_level(prio_a_ff, prio_b_ff);

	eifp_arbiter u_arb (
		.req   (src_req),
		.level (src_lvl),
		.pick  (pick)
	);

	assign cpu_req = cpu_req_ff;
	assign irq     = irq_ff;

	// ==================================================================
	// Register read decode
	always_comb begin
		rd_err = 1'b0;
		if (eifp_pkg::reg_hit(rd.addr, eifp_pkg::IDX_SENSE))
			rd_data = eifp_pkg::pack_flags(sense_ff);
		else if (eifp_pkg::reg_hit(rd.addr, eifp_pkg::IDX_ENABLE))
			rd_data = eifp_pkg::pack_flags(enable_ff);
		else if (eifp_pkg::reg_hit(rd.addr, eifp_pkg::IDX_FLAGS))
			rd_data = eifp_pkg::pack_flags(flag_ff);
		else if (eifp_pkg::reg_hit(rd.addr, eifp_pkg::IDX_PRIO_A))
			rd_data = prio_a_ff;
		else if (eifp_pkg::reg_hit(rd.addr, eifp_pkg::IDX_PRIO_B))
			rd_data = prio_b_ff;
		else if (eifp_pkg::reg_hit(rd.addr, eifp_pkg::IDX_EVT_STAT))
			rd_data = eifp_pkg::pack_flags(stat_ff);
		else if (eifp_pkg::reg_hit(rd.addr, eifp_pkg::IDX_EVT_MASK))
			rd_data = eifp_pkg::pack_flags(mask_ff);
		else begin
			rd_data = eifp_pkg::REG_RESET;
			rd_err  = 1'b1;
		end
	end

	assign rd_flags = rd.go
		&& eifp_pkg::reg_hit(rd.addr, eifp_pkg::IDX_FLAGS);
	assign rd_stat  = rd.go
		&& eifp_pkg::reg_hit(rd.addr, eifp_pkg::IDX_EVT_STAT);
	assign wr_flags = wr.go && wr.strb
		&& eifp_pkg::reg_hit(wr.addr, eifp_pkg::IDX_FLAGS);
	assign wr_bits  = eifp_pkg::unpack_flags(wr.data);

	// ==================================================================
	// Control register writes
	always_comb begin
		nxt_sense  = sense_ff;
		nxt_enable = enable_ff;
		nxt_prio_a = prio_a_ff;
		nxt_prio_b = prio_b_ff;
		nxt_mask   = mask_ff;
		wr_err     = 1'b0;
		if (!wr.go || !wr.strb)
			wr_err = 1'b0;
		else if (eifp_pkg::reg_hit(wr.addr, eifp_pkg::IDX_SENSE))
			nxt_sense = wr_bits;
		else if (eifp_pkg::reg_hit(wr.addr, eifp_pkg::IDX_ENABLE))
			nxt_enable = wr_bits;
		else if (eifp_pkg::reg_hit(wr.addr, eifp_pkg::IDX_PRIO_A))
			nxt_prio_a = wr.data;
		else if (eifp_pkg::reg_hit(wr.addr, eifp_pkg::IDX_PRIO_B))
			nxt_prio_b = wr.data;
		else if (eifp_pkg::reg_hit(wr.addr, eifp_pkg::IDX_EVT_MASK))
			nxt_mask = wr_bits;
		else if (!eifp_pkg::reg_hit(wr.addr, eifp_pkg::IDX_FLAGS)
			&& !eifp_pkg::reg_hit(wr.addr, eifp_pkg::IDX_EVT_STAT))
			wr_err = 1'b1;
	end

	// ==================================================================
	// Request flags
	always_comb begin
		for (int i = 0; i < eifp_pkg::FLAG_N; i++) begin
			set_lvl[i]  = !sense_ff[i] && !external_request_pin_n[i];
			set_edge[i] = sense_ff[i] && pin_prev_ff[i]
				&& !external_request_pin_n[i];
			ack_hit[i]  = cpu_ack.valid
				&& (cpu_ack.src == eifp_pkg::SRC_W'(i));
			// Level mode waits for the pin to return high
			auto_clr[i] = ack_hit[i] && (sense_ff[i]
				|| external_request_pin_n[i]);
			sw_clr[i]   = wr_flags && !wr_bits[i] && armed_ff[i];
		end
		set_any   = set_lvl | set_edge;
		// Set wins over both clears; a written 1 has no effect
		nxt_flag  = set_any | (flag_ff & ~(auto_clr | sw_clr));
		// Arm on a read of 1; any write to the flags disarms
		nxt_armed = (rd_flags ? flag_ff : armed_ff)
			& ~({3{wr_flags}} | ~nxt_flag);
		nxt_stat  = (stat_ff & ~{3{rd_stat}}) | (set_any & ~flag_ff);
		nxt_irq   = |(nxt_stat & mask_ff);
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			flag_ff     <= 3'h0;
			armed_ff    <= 3'h0;
			pin_prev_ff <= 3'h7;
			sense_ff    <= 3'h0;
			enable_ff   <= 3'h0;
			prio_a_ff   <= eifp_pkg::REG_RESET;
			prio_b_ff   <= eifp_pkg::REG_RESET;
			stat_ff     <= 3'h0;
			mask_ff     <= 3'h0;
			irq_ff      <= 1'b0;
			cpu_req_ff  <= '0;
		end else begin
			flag_ff     <= nxt_flag;
			armed_ff    <= nxt_armed;
			pin_prev_ff <= external_request_pin_n;
			sense_ff    <= nxt_sense;
			enable_ff   <= nxt_enable;
			prio_a_ff   <= nxt_prio_a;
			prio_b_ff   <= nxt_prio_b;
			stat_ff     <= nxt_stat;
			mask_ff     <= nxt_mask;
			irq_ff      <= nxt_irq;
			cpu_req_ff  <= pick;
		end
	end

	// ==================================================================
	// Checks
	for (genvar g = 0; g < eifp_pkg::FLAG_N; g++) begin : g_chk
		sequence s_read_one;
			rd_flags && flag_ff[g] && !wr_flags && !ack_hit[g];
		endsequence
		sequence s_quiet;
			(!wr_flags && !ack_hit[g]) [*3];
		endsequence
		sequence s_write_zero;
			wr_flags && !wr_bits[g] && !set_any[g];
		endsequence

		a_level_flag_set: assert property (
			@(posedge clk) disable iff (reset)
			!sense_ff[g] && !external_request_pin_n[g] |=> flag_ff[g])
			else $error("level request did not set flag");
		a_edge_flag_set: assert property (
			@(posedge clk) disable iff (reset)
			sense_ff[g] && $fell(external_request_pin_n[g]) |=> flag_ff[g])
			else $error("falling edge did not set flag");
		a_flag_rise_cause: assert property (
			@(posedge clk) disable iff (reset)
			$rose(flag_ff[g]) |-> $past(set_lvl[g] || set_edge[g]))
			else $error("flag rose without a request");
		a_write_one_kept: assert property (
			@(posedge clk) disable iff (reset)
			flag_ff[g] && wr_flags && wr_bits[g] && !ack_hit[g]
			|=> flag_ff[g])
			else $error("writing 1 cleared a flag");
		a_read_write_clear: assert property (
			@(posedge clk) disable iff (reset)
			s_read_one ##1 s_quiet ##1 s_write_zero |=> !flag_ff[g])
			else $error("read then write 0 left flag set");
		a_unarmed_no_clear: assert property (
			@(posedge clk) disable iff (reset)
			$fell(flag_ff[g]) |-> $past(armed_ff[g] && wr_flags
			|| ack_hit[g]))
			else $error("flag cleared without cause");
		a_edge_ack_clear: assert property (
			@(posedge clk) disable iff (reset)
			sense_ff[g] && ack_hit[g] && !set_any[g] |=> !flag_ff[g])
			else $error("edge flag kept after handling");
		a_level_ack_clear: assert property (
			@(posedge clk) disable iff (reset)
			!sense_ff[g] && ack_hit[g]
			|=> flag_ff[g] == !$past(external_request_pin_n[g]))
			else $error("level flag wrong after handling");
		a_stat_on_rise: assert property (
			@(posedge clk) disable iff (reset)
			$rose(flag_ff[g]) |-> stat_ff[g])
			else $error("flag rose without status event");
		a_stat_read_clear: assert property (
			@(posedge clk) disable iff (reset)
			rd_stat && !set_any[g] |=> !stat_ff[g])
			else $error("status bit kept after read");
		a_disabled_no_req: assert property (
			@(posedge clk) disable iff (reset)
			!enable_ff[g] && $stable(enable_ff[g])
			|-> !(cpu_req_ff.pending && cpu_req_ff.src == eifp_pkg::SRC_W'(g)))
			else $error("disabled pin offered to the CPU");
	end

	a_high_level_wins: assert property (
		@(posedge clk) disable iff (reset)
		|(src_req & src_lvl) && $stable(src_req) && $stable(src_lvl)
		|-> cpu_req_ff.pending && src_lvl[cpu_req_ff.src])
		else $error("low level source chosen over high");
	a_idle_no_pending: assert property (
		@(posedge clk) disable iff (reset)
		!(|src_req) && $stable(src_req) |-> !cpu_req_ff.pending)
		else $error("request offered with no source");
	a_irq_masked_stat: assert property (
		@(posedge clk) disable iff (reset)
		$stable(mask_ff) |-> irq_ff == |(stat_ff & mask_ff))
		else $error("interrupt output disagrees with status");

	// ==================================================================
	// Bus answers
	a_write_answer: assert property (
		@(posedge clk) disable iff (reset)
		wr.go |=> bvalid)
		else $error("write got no response");
	a_read_answer: assert property (
		@(posedge clk) disable iff (reset)
		rd.go |=> rvalid)
		else $error("read got no data");
endmodule
`default_nettype wire

// *** tb/eifp_cpu_model.sv ***
// CPU exception side model: takes handling of the offered source.
// Assumes cpu_req from the block under test, one clock domain.
`timescale 1ns/10ps
`default_nettype none
module eifp_cpu_model (
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                reset,
	// Behaviour control
	input  wire logic                en,
	input  wire logic [3:0]          dly,
	// Request in, acknowledge out
	input  wire eifp_pkg::eifp_req_s req,
	output eifp_pkg::eifp_ack_s      ack
);
	logic [3:0] cnt_ff;

	// ==================================================================
	// One-cycle acknowledge after dly+1 cycles of pending; with dly 0 it repeats on every pending cycle
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cnt_ff <= 4'h0;
			ack    <= '0;
		end else begin
			if (!en || !req.pending) begin
				cnt_ff <= 4'h0;
				ack    <= '0;
			end else if (cnt_ff == dly) begin
				ack    <= '{valid: 1'b1, src: req.src};
				cnt_ff <= 4'h0;
			end else begin
				cnt_ff <= cnt_ff + 4'h1;
				ack    <= '0;
			end
		end
	end
endmodule
`default_nettype wire

// *** tb/tb_external_irq_flags_and_priority.sv ***
// Self-checking bench of the external request flag block.
// Assumes eifp_top with eifp_cpu_model on its CPU side.
`timescale 1ns/10ps
`default_nettype none
module tb_external_irq_flags_and_priority;
	typedef struct packed {
		logic        w;
		logic [11:0] a;
		logic [7:0]  d;
		logic [31:0] e;
		logic [1:0]  r;
	} eifp_row_s;
	typedef struct packed {
		logic [7:0] a;
		logic [7:0] b;
		logic [3:0] s;
	} eifp_pri_s;
	localparam logic [1:0]  OK = eifp_pkg::RESP_OKAY;
	localparam logic [1:0]  SE = eifp_pkg::RESP_SLVERR;
	localparam logic [11:0] SNS = {eifp_pkg::IDX_SENSE, 2'h0};
	localparam logic [11:0] ENA = {eifp_pkg::IDX_ENABLE, 2'h0};
	localparam logic [11:0] FLG = {eifp_pkg::IDX_FLAGS, 2'h0};
	localparam logic [11:0] PRA = {eifp_pkg::IDX_PRIO_A, 2'h0};
	localparam logic [11:0] PRB = {eifp_pkg::IDX_PRIO_B, 2'h0};
	localparam logic [11:0] EVS = {eifp_pkg::IDX_EVT_STAT, 2'h0};
	localparam logic [11:0] MSK = {eifp_pkg::IDX_EVT_MASK, 2'h0};

	logic clk, reset, awvalid, wvalid, bready, arvalid, rready, ser, conv;
	logic awready, wready, bvalid, arready, rvalid, irq, cpu_en;
	logic [11:0]         awaddr, araddr;
	logic [31:0]         wdata, rdata, rd_v;
	logic [3:0]          wstrb, cpu_dly;
	logic [1:0]          bresp, rresp, rsp_v;
	logic [2:0]          pin_n;
	logic [4:0]          tmr;
	eifp_pkg::eifp_ack_s ack;
	eifp_pkg::eifp_req_s req;
	int                  error_cnt, n_tests, n_ack;

	eifp_row_s rows [19] = '{
		'{0, SNS, 8'h00, 0, OK}, '{0, ENA, 8'h00, 0, OK},
		'{0, FLG, 8'h00, 0, OK}, '{0, PRA, 8'h00, 0, OK},
		'{0, PRB, 8'h00, 0, OK}, '{0, EVS, 8'h00, 0, OK},
		'{0, MSK, 8'h00, 0, OK}, '{1, SNS, 8'hFF, 32'h13, OK},
		'{1, ENA, 8'hFF, 32'h13, OK}, '{1, PRA, 8'hD7, 32'hD7, OK},
		'{1, PRB, 8'hCA, 32'hCA, OK}, '{1, MSK, 8'hFF, 32'h13, OK},
		'{1, 12'h000, 8'h55, 0, SE}, '{1, FLG, 8'hFF, 0, OK},
		'{1, SNS, 8'h00, 0, OK}, '{1, ENA, 8'h00, 0, OK},
		'{1, PRA, 8'h00, 0, OK}, '{1, PRB, 8'h00, 0, OK},
		'{1, MSK, 8'h00, 0, OK}};
	eifp_pri_s pri [9] = '{
		'{8'h00, 8'h00, 4'h3}, '{8'h01, 8'h00, 4'h5}, '{8'h02, 8'h00, 4'h4},
		'{8'h00, 8'h80, 4'h6}, '{8'h00, 8'h40, 4'h7}, '{8'h00, 8'h08, 4'h8},
		'{8'h00, 8'h02, 4'h9}, '{8'h04, 8'h02, 4'h3}, '{8'h00, 8'h0A, 4'h8}};

	eifp_top i_eifp_top (.clk(clk), .reset(reset), .awvalid(awvalid),
		.awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
		.wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
		.bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.external_request_pin_n(pin_n), .timer_unit_req(tmr),
		.serial_unit_req(ser), .converter_req(conv), .cpu_ack(ack),
		.cpu_req(req), .irq(irq));
	eifp_cpu_model i_eifp_cpu_model (.clk(clk), .reset(reset), .en(cpu_en),
		.dly(cpu_dly), .req(req), .ack(ack));

	// ==================================================================
	// Clock, acknowledge count, watchdog
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) if (ack.valid === 1'b1) n_ack++;
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		give_verdict();
	end

	// ==================================================================
	// Tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic ta, tw, done;
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		done = 1'b0;
		while (!done) begin
			@(negedge clk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			done = bvalid;
			rsp_v = bresp;
			@(posedge clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a);
		logic ta, done;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		done = 1'b0;
		while (!done) begin
			@(negedge clk);
			ta = arvalid && arready;
			done = rvalid;
			rd_v = rdata;
			rsp_v = rresp;
			@(posedge clk);
			if (ta) arvalid <= 1'b0;
		end
		rready <= 1'b0;
	endtask
	task automatic give_verdict;
		$display("Comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// ==================================================================
	// Main sequence
	initial begin
		{reset, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
		{ser, conv, cpu_en, awaddr, araddr, wdata, tmr} = '0;
		{wstrb, cpu_dly, pin_n} = {4'hF, 4'h2, 3'h7};
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		foreach (rows[i]) begin
			if (rows[i].w) wr(rows[i].a, rows[i].d);
			if (rows[i].w) chk(rsp_v, rows[i].r);
			rd(rows[i].a);
			chk(rd_v, rows[i].e);
			chk(rsp_v, rows[i].r);
		end
		wstrb <= 4'hE;
		wr(PRA, 8'h55);
		chk(rsp_v, OK);
		wstrb <= 4'hF;
		rd(PRA);
		chk(rd_v, 32'h00);
		$display("Register test done");
		{tmr, ser, conv} <= 7'h7F;
		foreach (pri[i]) begin
			wr(PRA, pri[i].a);
			wr(PRB, pri[i].b);
			@(negedge clk);
			chk({27'h0, req}, {27'h0, 1'b1, pri[i].s});
		end
		@(posedge clk);
		{tmr, ser, conv} <= 7'h00;
		wr(PRA, 8'h00);
		wr(PRB, 8'h00);
		$display("Priority test done");
		pin_n <= 3'h6;
		repeat (2) @(posedge clk);
		pin_n <= 3'h7;
		rd(FLG);
		chk(rd_v, 32'h01);
		chk({31'h0, irq}, 32'h0);
		wr(FLG, 8'h01);
		wr(FLG, 8'h00);
		rd(FLG);
		chk(rd_v, 32'h01);
		wr(FLG, 8'h00);
		rd(FLG);
		chk(rd_v, 32'h00);
		wr(MSK, 8'h01);
		@(negedge clk);
		chk({31'h0, irq}, 32'h1);
		rd(EVS);
		chk(rd_v, 32'h01);
		@(negedge clk);
		chk({31'h0, irq}, 32'h0);
		$display("Level and clear test done");
		wr(SNS, 8'h13);
		pin_n <= 3'h5;
		rd(FLG);
		chk(rd_v, 32'h02);
		wr(FLG, 8'h00);
		rd(FLG);
		chk(rd_v, 32'h00);
		pin_n <= 3'h7;
		wr(ENA, 8'h13);
		cpu_en <= 1'b1;
		pin_n <= 3'h3;
		repeat (12) @(posedge clk);
		rd(FLG);
		chk(rd_v, 32'h00);
		pin_n <= 3'h7;
		wr(SNS, 8'h00);
		cpu_dly <= 4'h8;
		pin_n <= 3'h6;
		@(posedge clk);
		pin_n <= 3'h7;
		repeat (16) @(posedge clk);
		rd(FLG);
		chk(rd_v, 32'h00);
		chk(n_ack, 32'd2);
		$display("Acknowledge test done");
		pin_n <= 3'h6;
		repeat (3) @(posedge clk);
		reset <= 1'b1;
		@(negedge clk);
		chk({26'h0, req, irq}, 32'h0);
		chk({29'h0, awready, wready, arready}, 32'h7);
		@(posedge clk);
		reset <= 1'b0;
		pin_n <= 3'h7;
		rd(ENA);
		chk(rd_v, 32'h00);
		$display("Reset test done");
		give_verdict();
	end
endmodule
`default_nettype wire
